// ---- hdl/rcm_params.svh ----
// Purpose: Constants for the reference comparator control block
// Assumes: Eight-bit registers at offsets 0 to 3 of the module base
// Notes: Included by rcm_edge_detect and rcm_ctrl
`ifndef RCM_PARAMS_SVH
`define RCM_PARAMS_SVH

// ======================================================================
// Register offsets
`define RCM_OFS_CS 2'h0
`define RCM_OFS_C0 2'h1
`define RCM_OFS_C1 2'h2
`define RCM_OFS_C2 2'h3

// ======================================================================
// Field positions
`define RCM_CS_EN 7
`define RCM_CS_FLAG 6
`define RCM_CS_OPE 4
`define RCM_CS_RES 3
`define RCM_CS_EDGE_HI 2
`define RCM_CS_EDGE_LO 1
`define RCM_CS_IEN 0
`define RCM_C0_CHWT 7
`define RCM_C0_PSEL_HI 6
`define RCM_C0_PSEL_LO 4
`define RCM_C0_RHWT 3
`define RCM_C0_NSEL_HI 2
`define RCM_C0_NSEL_LO 0
`define RCM_C1_EN 7
`define RCM_C1_SRC 6
`define RCM_C1_LVL_HI 4
`define RCM_C1_LVL_LO 0

// ======================================================================
// Reset values and timing
`define RCM_RST_BYTE 8'h00
`define RCM_FLAG_LAG 2

`endif

// ---- hdl/rcm_pkg.sv ----
// Purpose: Shared types of the reference comparator control block
// Assumes: Edge select encoding follows declaration order
// Notes: Constants live in rcm_params.svh
package rcm_pkg;
   // Edge choice, encoded 00 to 11 in declaration order, 11 reserved
   typedef enum logic [1:0] {RCM_EDGE_BOTH, RCM_EDGE_FALL, RCM_EDGE_RISE, RCM_EDGE_RSVD} rcm_edge_t;
endpackage

// ---- hdl/rcm_sync_if.sv ----
// Purpose: Carries enable, edge choice and synchronized result between control and detector
// Assumes: Single clock domain
// Notes: ctrl side drives configuration, det side returns samples
`timescale 1ns/100ps
interface rcm_sync_if;
   import rcm_pkg::*;
   logic active;
   rcm_edge_t edge_sel;
   logic result;
   logic edge_hit;
   modport ctrl (output active, output edge_sel, input result, input edge_hit);
   modport det (input active, input edge_sel, output result, output edge_hit);
endinterface

// ---- hdl/rcm_edge_detect.sv ----
// Purpose: Synchronizes the comparator output and detects the selected edge
// Assumes: cmp_raw is asynchronous to sys_clk
// Notes: edge_hit is a one-cycle pulse one clock after the result bit moves
`timescale 1ns/100ps
`include "rcm_params.svh"
module rcm_edge_detect
   import rcm_pkg::*;
(
   // Clock and reset
   input wire logic sys_clk,
   input wire logic arst_n,
   input wire logic clk_en,
   input wire logic soft_rst,
   // Comparator output
   input wire logic cmp_raw,
   // Control side
   rcm_sync_if.det sif
);
   logic sync1_q;
   logic sync2_q;
   logic prev_q;
   logic hit_q;
   wire logic clear_all;
   wire logic hit_d;

   // ======================================================================
   // Synchronizer and edge compare
   assign clear_all = soft_rst | ~sif.active;
   assign hit_d = (sif.edge_sel == RCM_EDGE_BOTH) ? (sync2_q ^ prev_q) :
                  (sif.edge_sel == RCM_EDGE_FALL) ? (prev_q & ~sync2_q) :
                  (sif.edge_sel == RCM_EDGE_RISE) ? (sync2_q & ~prev_q) : 1'b0;

   always_ff @(posedge sys_clk or negedge arst_n)
   begin
      if (!arst_n)
      begin
         sync1_q <= 1'b0;
         sync2_q <= 1'b0;
         prev_q <= 1'b0;
         hit_q <= 1'b0;
      end
      else if (clk_en)   // Frozen while the bus clock is stopped
      begin
         if (clear_all)   // Result reads 0 when disabled
         begin
            sync1_q <= 1'b0;
            sync2_q <= 1'b0;
            prev_q <= 1'b0;
            hit_q <= 1'b0;
         end
         else
         begin
            sync1_q <= cmp_raw;
            sync2_q <= sync1_q;
            prev_q <= sync2_q;
            hit_q <= hit_d;
         end
      end
   end

   assign sif.result = sync2_q;
   assign sif.edge_hit = hit_q;

   // ======================================================================
   // Assertions
   property p_sync_depth;
      @(posedge sys_clk) disable iff (!arst_n || !clk_en || soft_rst)
      // First cycle must be a clocked one: a frozen edge does not move the synchronizer
      sif.active && clk_en ##1 sif.active ##1 sif.active |-> sync2_q == $past(cmp_raw, 2);
   endproperty
   AST_SYNC_DEPTH: assert property (p_sync_depth) else $error("Result is not the raw output two clocks late");

   AST_RSVD_NO_EDGE: assert property (@(posedge sys_clk) disable iff (!arst_n || !clk_en || soft_rst)
      (sif.edge_sel == RCM_EDGE_RSVD) && sif.active |=> !hit_q)
      else $error("Reserved edge select produced an edge");

   AST_FALL_EDGE: assert property (@(posedge sys_clk) disable iff (!arst_n || !clk_en || soft_rst)
      (sif.edge_sel == RCM_EDGE_FALL) && sif.active && $past(sif.active) && $fell(sync2_q) |=> hit_q)
      else $error("Falling edge not detected");
endmodule // rcm_edge_detect

// ---- hdl/rcm_ctrl.sv ----
// Purpose: Register file and digital control of the reference comparator
// Assumes: Eight-bit register port at base offsets 0 to 3; analog core outside
// Notes: clk_en low models the stopped bus clock of stop3
`timescale 1ns/100ps
`include "rcm_params.svh"
module rcm_ctrl
   import rcm_pkg::*;
#(
   parameter int N_INPUTS = 7,
   parameter int LEVEL_W = 5
)
(
   // Clock and reset
   input wire logic sys_clk,
   input wire logic arst_n,
   input wire logic clk_en,
   // Low-power mode inputs
   input wire logic stop3_mode,
   input wire logic stop2_wake_rst,
   // Register port
   input wire logic reg_sel,
   input wire logic [1:0] reg_addr,
   input wire logic reg_wr,
   input wire logic reg_rd,
   input wire logic [7:0] reg_wdata,
   output logic [7:0] reg_rdata,
   // Analog core side
   input wire logic cmp_raw,
   input wire logic hw_trigger,
   output logic cmp_power_en,
   output logic refgen_power_en,
   output logic [2:0] positive_input_select,
   output logic [2:0] negative_input_select,
   output logic refgen_source_select,
   output logic [LEVEL_W-1:0] refgen_level_code,
   output logic [N_INPUTS-1:0] analog_input_pin_enable,
   // Output pad
   output logic cmp_pin_out,
   output logic cmp_pin_oe_n,
   // Interrupts
   output logic cpu_irq,
   output logic wake_irq
);
   // ======================================================================
   // Register state
   logic comparator_enable_q;
   logic compare_edge_flag_q;
   logic output_pin_enable_q;
   rcm_edge_t edge_sensitivity_select_q;
   logic compare_irq_enable_q;
   logic comparator_hw_trigger_select_q;
   logic [2:0] positive_input_select_q;
   logic refgen_hw_trigger_select_q;
   logic [2:0] negative_input_select_q;
   logic refgen_enable_q;
   logic refgen_source_select_q;
   logic [LEVEL_W-1:0] refgen_level_code_q;
   logic [N_INPUTS-1:0] analog_input_pin_enable_q;
   logic trig_s1_q;
   logic trig_s2_q;
   logic [7:0] rdata_q;
   logic pin_out_q;
   logic pin_oe_n_q;
   logic flag_d;
   // Reset image of the control/status register, indexed by field position
   localparam logic [7:0] CS_RST = `RCM_RST_BYTE;

   rcm_sync_if sif ();

   // ======================================================================
   // Address decode
   wire logic wr_cs = reg_sel & reg_wr & (reg_addr == `RCM_OFS_CS);
   wire logic wr_c0 = reg_sel & reg_wr & (reg_addr == `RCM_OFS_C0);
   wire logic wr_c1 = reg_sel & reg_wr & (reg_addr == `RCM_OFS_C1);
   wire logic wr_c2 = reg_sel & reg_wr & (reg_addr == `RCM_OFS_C2);
   wire logic rd_any = reg_sel & reg_rd & ~reg_wr;
   wire logic flag_clr = wr_cs & ~reg_wdata[`RCM_CS_FLAG];

   // ======================================================================
   // Read data assembly, reserved bits read 0
   wire logic [7:0] cs_view = {comparator_enable_q, compare_edge_flag_q, 1'b0, output_pin_enable_q,
                               sif.result, edge_sensitivity_select_q, compare_irq_enable_q};
   wire logic [7:0] c0_view = {comparator_hw_trigger_select_q, positive_input_select_q,
                               refgen_hw_trigger_select_q, negative_input_select_q};
   wire logic [7:0] c1_view = {refgen_enable_q, refgen_source_select_q, 1'b0, refgen_level_code_q};
   wire logic [7:0] c2_view = {1'b0, analog_input_pin_enable_q};
   wire logic [7:0] read_mux = (reg_addr == `RCM_OFS_CS) ? cs_view :
                               (reg_addr == `RCM_OFS_C0) ? c0_view :
                               (reg_addr == `RCM_OFS_C1) ? c1_view : c2_view;

   // ======================================================================
   // Gated enables to the analog core
   wire logic cmp_active = comparator_enable_q & (~comparator_hw_trigger_select_q | trig_s2_q);
   wire logic refgen_active = refgen_enable_q & (~refgen_hw_trigger_select_q | trig_s2_q);

   // ======================================================================
   // Configuration registers
   always_ff @(posedge sys_clk or negedge arst_n)
   begin
      if (!arst_n)
      begin
         comparator_enable_q <= CS_RST[`RCM_CS_EN];
         output_pin_enable_q <= CS_RST[`RCM_CS_OPE];
         edge_sensitivity_select_q <= RCM_EDGE_BOTH;
         compare_irq_enable_q <= CS_RST[`RCM_CS_IEN];
      end
      else if (clk_en)
      begin
         if (stop2_wake_rst)
         begin
            comparator_enable_q <= CS_RST[`RCM_CS_EN];
            output_pin_enable_q <= CS_RST[`RCM_CS_OPE];
            edge_sensitivity_select_q <= RCM_EDGE_BOTH;
            compare_irq_enable_q <= CS_RST[`RCM_CS_IEN];
         end
         else if (wr_cs)
         begin
            comparator_enable_q <= reg_wdata[`RCM_CS_EN];
            output_pin_enable_q <= reg_wdata[`RCM_CS_OPE];
            edge_sensitivity_select_q <= rcm_edge_t'(reg_wdata[`RCM_CS_EDGE_HI:`RCM_CS_EDGE_LO]);
            compare_irq_enable_q <= reg_wdata[`RCM_CS_IEN];
         end
      end
   end

   always_ff @(posedge sys_clk or negedge arst_n)
   begin
      if (!arst_n)
      begin
         comparator_hw_trigger_select_q <= 1'b0;
         positive_input_select_q <= 3'h0;
         refgen_hw_trigger_select_q <= 1'b0;
         negative_input_select_q <= 3'h0;
      end
      else if (clk_en)
      begin
         if (stop2_wake_rst)
         begin
            comparator_hw_trigger_select_q <= 1'b0;
            positive_input_select_q <= 3'h0;
            refgen_hw_trigger_select_q <= 1'b0;
            negative_input_select_q <= 3'h0;
         end
         else if (wr_c0)
         begin
            comparator_hw_trigger_select_q <= reg_wdata[`RCM_C0_CHWT];
            positive_input_select_q <= reg_wdata[`RCM_C0_PSEL_HI:`RCM_C0_PSEL_LO];
            refgen_hw_trigger_select_q <= reg_wdata[`RCM_C0_RHWT];
            negative_input_select_q <= reg_wdata[`RCM_C0_NSEL_HI:`RCM_C0_NSEL_LO];
         end
      end
   end

   always_ff @(posedge sys_clk or negedge arst_n)
   begin
      if (!arst_n)
      begin
         refgen_enable_q <= 1'b0;
         refgen_source_select_q <= 1'b0;
         refgen_level_code_q <= '0;
         analog_input_pin_enable_q <= '0;
      end
      else if (clk_en)
      begin
         if (stop2_wake_rst)
         begin
            refgen_enable_q <= 1'b0;
            refgen_source_select_q <= 1'b0;
            refgen_level_code_q <= '0;
            analog_input_pin_enable_q <= '0;
         end
         else
         begin
            if (wr_c1)
            begin
               refgen_enable_q <= reg_wdata[`RCM_C1_EN];
               refgen_source_select_q <= reg_wdata[`RCM_C1_SRC];
               refgen_level_code_q <= reg_wdata[LEVEL_W-1:0];
            end
            if (wr_c2)
               analog_input_pin_enable_q <= reg_wdata[N_INPUTS-1:0];
         end
      end
   end

   // ======================================================================
   // Edge flag: a new edge wins over a clearing write
   assign flag_d = sif.edge_hit ? 1'b1 : (flag_clr ? 1'b0 : compare_edge_flag_q);

   always_ff @(posedge sys_clk or negedge arst_n)
   begin
      if (!arst_n)
         compare_edge_flag_q <= 1'b0;
      else if (clk_en)
         compare_edge_flag_q <= stop2_wake_rst ? 1'b0 : flag_d;
   end

   // ======================================================================
   // Trigger synchronizer, pad and read data registers
   always_ff @(posedge sys_clk or negedge arst_n)
   begin
      if (!arst_n)
      begin
         trig_s1_q <= 1'b0;
         trig_s2_q <= 1'b0;
         rdata_q <= 8'h00;
         pin_out_q <= 1'b0;
         pin_oe_n_q <= 1'b1;
      end
      else if (clk_en)
      begin
         trig_s1_q <= hw_trigger;
         trig_s2_q <= trig_s1_q;
         if (rd_any)
            rdata_q <= read_mux;
         pin_out_q <= sif.result & output_pin_enable_q;
         pin_oe_n_q <= ~output_pin_enable_q;
      end
   end

   // ======================================================================
   // Detector
   assign sif.active = cmp_active;
   assign sif.edge_sel = edge_sensitivity_select_q;

   rcm_edge_detect u_edge
   (
      .sys_clk(sys_clk),
      .arst_n(arst_n),
      .clk_en(clk_en),
      .soft_rst(stop2_wake_rst),
      .cmp_raw(cmp_raw),
      .sif(sif)
   );

   // ======================================================================
   // Asynchronous wake: raw output against the held result bit
   wire logic raw_rise = cmp_raw & ~sif.result;
   wire logic raw_fall = ~cmp_raw & sif.result;
   wire logic raw_edge = (edge_sensitivity_select_q == RCM_EDGE_BOTH) ? (raw_rise | raw_fall) :
                         (edge_sensitivity_select_q == RCM_EDGE_FALL) ? raw_fall :
                         (edge_sensitivity_select_q == RCM_EDGE_RISE) ? raw_rise : 1'b0;
   assign wake_irq = stop3_mode & compare_irq_enable_q & cmp_active & raw_edge;

   // ======================================================================
   // Outputs
   assign cpu_irq = compare_edge_flag_q & compare_irq_enable_q;
   assign cmp_power_en = cmp_active;
   assign refgen_power_en = refgen_active;
   assign positive_input_select = positive_input_select_q;
   assign negative_input_select = negative_input_select_q;
   assign refgen_source_select = refgen_source_select_q;
   assign refgen_level_code = refgen_level_code_q;
   assign analog_input_pin_enable = analog_input_pin_enable_q;
   assign cmp_pin_out = pin_out_q;
   assign cmp_pin_oe_n = pin_oe_n_q;
   assign reg_rdata = rdata_q;

   // ======================================================================
   // Assertions
   default clocking cb @(posedge sys_clk); endclocking
   default disable iff (!arst_n || !clk_en || stop2_wake_rst);

   AST_EN_WRITE: assert property (wr_cs && reg_wdata[`RCM_CS_EN] && !comparator_hw_trigger_select_q && !wr_c0
      |=> cmp_power_en)
      else $error("Comparator not enabled after enable write");

   AST_HWT_GATE: assert property (comparator_hw_trigger_select_q && !trig_s2_q |-> !cmp_power_en)
      else $error("Comparator runs with trigger low");

   sequence s_rise_seen;
      sif.active && (edge_sensitivity_select_q == RCM_EDGE_RISE) && $rose(sif.result) ##1 sif.active;
   endsequence
   AST_FLAG_LAG: assert property (s_rise_seen |=> compare_edge_flag_q)
      else $error("Flag not set two clocks after result rose");

   AST_FLAG_EARLY: assert property ($rose(compare_edge_flag_q) |-> $past(sif.edge_hit))
      else $error("Flag set without a detected edge");

   AST_FLAG_CLEAR: assert property (flag_clr && !sif.edge_hit |=> !compare_edge_flag_q)
      else $error("Writing 0 did not clear the flag");

   AST_FLAG_W1: assert property (wr_cs && reg_wdata[`RCM_CS_FLAG] && compare_edge_flag_q |=> compare_edge_flag_q)
      else $error("Writing 1 changed the flag");

   AST_FLAG_STICKY: assert property (compare_edge_flag_q && !flag_clr |=> compare_edge_flag_q)
      else $error("Flag dropped without a clearing write");

   AST_RESULT_OFF: assert property (!cmp_active |=> !sif.result)
      else $error("Result bit nonzero while disabled");

   AST_IRQ: assert property (sif.edge_hit && compare_irq_enable_q && !wr_cs |=> cpu_irq)
      else $error("No interrupt after edge with enable set");

   AST_PAD: assert property (!output_pin_enable_q |=> cmp_pin_oe_n && !cmp_pin_out)
      else $error("Pad driven while output pin disabled");

   AST_REFGEN_OFF: assert property (wr_c1 && !reg_wdata[`RCM_C1_EN] |=> !refgen_power_en)
      else $error("Generator still on after disable write");

   COV_FLAG_SET: cover property ($rose(compare_edge_flag_q));
   COV_IRQ: cover property ($rose(cpu_irq));
   COV_FLAG_RACE: cover property (sif.edge_hit && flag_clr);
   COV_WAKE: cover property (wake_irq);
endmodule // rcm_ctrl

// ---- verification/rcm_cmp_model.sv ----
// Purpose: Behavioural analog core: reference generator, input muxes, comparator
// Assumes: Voltages counted in thirty-seconds of the generator source
// Notes: DLY sets how slowly the comparator output answers
`timescale 1ns/100ps
module rcm_cmp_model
#(
   parameter int DLY = 3
)
(
   // Control from the block
   input wire logic cmp_power_en,
   input wire logic refgen_power_en,
   input wire logic [2:0] positive_input_select,
   input wire logic [2:0] negative_input_select,
   input wire logic [4:0] refgen_level_code,
   input wire logic [6:0] analog_input_pin_enable,
   // Pin voltages
   input wire logic [6:0][5:0] pin_v,
   // Comparator output
   output logic cmp_raw
);
   int vp;
   int vn;
   int vref;
   // ======================================================================
   // Input selection
   assign vref = refgen_power_en ? int'(refgen_level_code) + 1 : 0;
   assign vp = (positive_input_select == 3'h7) ? vref :
      (analog_input_pin_enable[positive_input_select] ? int'(pin_v[positive_input_select]) : 0);
   assign vn = (negative_input_select == 3'h7) ? vref :
      (analog_input_pin_enable[negative_input_select] ? int'(pin_v[negative_input_select]) : 0);
   // ======================================================================
   // Comparator, low while unpowered
   initial cmp_raw = 1'b0;
   always @(cmp_power_en, vp, vn) cmp_raw <= #DLY cmp_power_en && (vp > vn);
endmodule // rcm_cmp_model

// ---- verification/tb_top.sv ----
// Purpose: Self-checking bench of the reference comparator control block
// Assumes: Analog core modelled by rcm_cmp_model; pin 0 versus generator level 16
// Notes: Each scenario is one task
`timescale 1ns/100ps
module tb_top;
   logic sys_clk = 1'b0, arst_n = 1'b0, clk_en = 1'b1, stop3_mode = 1'b0, stop2_wake_rst = 1'b0;
   logic reg_sel = 1'b0, reg_wr = 1'b0, reg_rd = 1'b0, hw_trigger = 1'b0;
   logic [1:0] reg_addr = 2'h0;
   logic [7:0] reg_wdata = 8'h00, reg_rdata, d;
   logic cmp_raw, cmp_power_en, refgen_power_en, refgen_source_select, cmp_pin_out, cmp_pin_oe_n, cpu_irq, wake_irq;
   logic [2:0] positive_input_select, negative_input_select;
   logic [4:0] refgen_level_code;
   logic [6:0] analog_input_pin_enable;
   logic [6:0][5:0] pin_v = '0;
   int mismatches = 0, n_checks = 0;

   initial forever #4 sys_clk = ~sys_clk;

   rcm_ctrl u_dut (.sys_clk, .arst_n, .clk_en, .stop3_mode, .stop2_wake_rst, .reg_sel, .reg_addr, .reg_wr,
      .reg_rd, .reg_wdata, .reg_rdata, .cmp_raw, .hw_trigger, .cmp_power_en, .refgen_power_en,
      .positive_input_select, .negative_input_select, .refgen_source_select, .refgen_level_code,
      .analog_input_pin_enable, .cmp_pin_out, .cmp_pin_oe_n, .cpu_irq, .wake_irq);
   rcm_cmp_model u_core (.cmp_power_en, .refgen_power_en, .positive_input_select, .negative_input_select,
      .refgen_level_code, .analog_input_pin_enable, .pin_v, .cmp_raw);

   // ======================================================================
   // Bus cycles and comparison
   task automatic chk(input logic [7:0] got, input logic [7:0] exp);
      n_checks++;
      if (got !== exp)
      begin
         mismatches++;
         $display("FAIL t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask
   task automatic wr(input logic [1:0] a, input logic [7:0] v);
      @(posedge sys_clk);
      reg_sel <= 1'b1;
      reg_wr <= 1'b1;
      reg_addr <= a;
      reg_wdata <= v;
      @(posedge sys_clk);
      reg_sel <= 1'b0;
      reg_wr <= 1'b0;
   endtask
   task automatic rd(input logic [1:0] a, output logic [7:0] v);
      @(posedge sys_clk);
      reg_sel <= 1'b1;
      reg_rd <= 1'b1;
      reg_addr <= a;
      @(posedge sys_clk);
      reg_sel <= 1'b0;
      reg_rd <= 1'b0;
      #1 v = reg_rdata;
   endtask
   task automatic cyc(input int n);
      repeat (n) @(posedge sys_clk);
      #1;
   endtask
   task automatic setv(input logic [5:0] v);
      @(posedge sys_clk);
      pin_v[0] <= v;
   endtask
   // Level code before generator enable, inputs before comparator, then flag clear
   task automatic cfg(input logic [7:0] cs);
      wr(2'h2, 8'h0f);
      wr(2'h2, 8'h8f);
      wr(2'h1, 8'h07);
      wr(2'h3, 8'h01);
      wr(2'h0, cs);
      wr(2'h0, cs);
   endtask

   // ======================================================================
   // Scenarios
   task automatic t_reset;
      for (int a = 0; a < 4; a++)
      begin
         rd(a[1:0], d);
         chk(d, 8'h00);
      end
      chk({cmp_pin_oe_n, cmp_power_en, refgen_power_en, cpu_irq, 4'h0}, 8'h80);
   endtask
   task automatic t_regs;
      wr(2'h0, 8'hff);
      rd(2'h0, d);
      chk(d, 8'h97);
      wr(2'h1, 8'hff);
      rd(2'h1, d);
      chk(d, 8'hff);
      wr(2'h2, 8'hff);
      rd(2'h2, d);
      chk(d, 8'hdf);
      wr(2'h3, 8'hff);
      rd(2'h3, d);
      chk(d, 8'h7f);
      chk({positive_input_select, negative_input_select, refgen_source_select, cmp_power_en}, 8'hfe);
      chk({3'h0, refgen_level_code}, 8'h1f);
      chk({refgen_power_en, analog_input_pin_enable}, 8'h7f);
      @(posedge sys_clk);
      hw_trigger <= 1'b1;
      cyc(4);
      chk({6'h0, cmp_power_en, refgen_power_en}, 8'h03);
      @(posedge sys_clk);
      hw_trigger <= 1'b0;
      for (int a = 0; a < 4; a++)
         wr(a[1:0], 8'h00);
      cyc(4);
      chk({6'h0, cmp_power_en, refgen_power_en}, 8'h00);
   endtask
   task automatic t_edges(input logic [1:0] es);
      logic [7:0] cs;
      logic rise_ok;
      logic fall_ok;
      cs = {4'b1001, 1'b0, es, 1'b1};
      rise_ok = (es == 2'b00) || (es == 2'b10);
      fall_ok = (es == 2'b00) || (es == 2'b01);
      cfg(cs);
      setv(6'd20);
      for (int i = 0; i < 20 && cmp_pin_out !== 1'b1; i++)
         cyc(1);
      chk({7'h0, cpu_irq}, 8'h00);
      chk({6'h0, cmp_pin_out, cmp_pin_oe_n}, 8'h02);
      cyc(1);
      chk({7'h0, cpu_irq}, {7'h0, rise_ok});
      rd(2'h0, d);
      chk(d, cs | 8'h08 | {1'b0, rise_ok, 6'h00});
      wr(2'h0, cs | 8'h40);
      rd(2'h0, d);
      chk(d, cs | 8'h08 | {1'b0, rise_ok, 6'h00});
      wr(2'h0, cs);
      rd(2'h0, d);
      chk(d, cs | 8'h08);
      setv(6'd10);
      cyc(6);
      rd(2'h0, d);
      chk(d, cs | {1'b0, fall_ok, 6'h00});
      chk({7'h0, cpu_irq}, {7'h0, fall_ok});
      wr(2'h0, cs & 8'hee);
      cyc(2);
      chk({6'h0, cpu_irq, cmp_pin_oe_n}, 8'h01);
      wr(2'h0, 8'h00);
   endtask
   task automatic t_stop3;
      cfg(8'h81);
      setv(6'd20);
      cyc(6);
      wr(2'h0, 8'h81);
      rd(2'h0, d);
      chk(d, 8'h89);
      @(posedge sys_clk);
      clk_en <= 1'b0;
      stop3_mode <= 1'b1;
      pin_v[0] <= 6'd10;
      cyc(3);
      chk({7'h0, wake_irq}, 8'h01);
      @(posedge sys_clk);
      clk_en <= 1'b1;
      stop3_mode <= 1'b0;
      cyc(6);
      rd(2'h0, d);
      chk(d, 8'hc1);
      setv(6'd20);
      cyc(6);
      wr(2'h0, 8'h01);
      rd(2'h0, d);
      chk(d, 8'h01);
      wr(2'h3, 8'h7f);
      @(posedge sys_clk);
      stop2_wake_rst <= 1'b1;
      @(posedge sys_clk);
      stop2_wake_rst <= 1'b0;
      rd(2'h3, d);
      chk(d, 8'h00);
      rd(2'h0, d);
      chk(d, 8'h00);
   endtask

   // ======================================================================
   // Verdict and sequence
   task automatic end_sim;
      $display("checks=%0d mismatches=%0d", n_checks, mismatches);
      if (mismatches == 0 && n_checks > 0)
         $display("NO MISMATCHES");
      else
         $display("MISMATCHES SEEN");
      $finish;
   endtask
   initial
   begin
      #100000;
      mismatches++;
      end_sim;
   end
   initial
   begin
      repeat (6) @(posedge sys_clk);
      arst_n <= 1'b1;
      t_reset;
      t_regs;
      for (int es = 0; es < 4; es++)
         t_edges(es[1:0]);
      t_stop3;
      end_sim;
   end
endmodule // tb_top
